//--- pkg/adc_port_pkg.sv
// constants and types shared by the converter host port
package adc_port_pkg;

   // ========================================================
   // register indexes (byte address is four times the index)
   localparam logic [29:0] IDX_STATUS   = 30'h1080_0000;
   localparam logic [29:0] IDX_CONTROL  = 30'h10f0_0000;
   localparam logic [29:0] IDX_RES_LOW  = 30'h10f0_0000;
   localparam logic [29:0] IDX_RES_HIGH = 30'h10f0_0001;
   localparam logic [29:0] IDX_OPTION   = 30'h2240_0000;

   // ========================================================
   // field positions
   localparam int STATUS_BUSY_BIT = 7;
   localparam int OPTION_FIT_BIT  = 0;
   localparam int RES_BITS        = 12;

   // ========================================================
   // values after reset
   localparam logic [2:0]  MODE_RESET   = 3'h2;
   localparam logic [15:0] RESULT_RESET = 16'h0000;
   localparam logic [11:0] CODE_RESET   = 12'h000;

   // ========================================================
   // timing
   localparam int CLK_PERIOD_NS   = 20;
   localparam int CONV_TIME_NS    = 12000;
   localparam int CONV_CYC        = CONV_TIME_NS / CLK_PERIOD_NS;
   localparam int BIT_CYC         = CONV_CYC / RES_BITS;
   localparam int SAMPLE_RATE_MAX = 60000;
   localparam int SAMPLE_CYC      = 1000000000 / CLK_PERIOD_NS
                                    / SAMPLE_RATE_MAX;
   localparam logic [5:0] BIT_LAST = 6'(BIT_CYC - 1);

   // ========================================================
   // control byte layout
   typedef struct packed {
      logic [2:0] mode;
      logic       span_10v;
      logic       bipolar;
      logic [2:0] channel;
   } ctrl_t;

   // avalon request bundle
   typedef struct packed {
      logic [31:0] address;
      logic        read;
      logic        write;
      logic [31:0] writedata;
      logic [3:0]  byteenable;
   } avs_req_t;

endpackage : adc_port_pkg

//--- testbench/adc_frontend_model.sv
// analog front end model: per-channel input levels and a comparator
`timescale 1ns/1ps
`default_nettype none

module adc_frontend_model (
   // selection and trial code from the port
   input  wire logic [2:0]       afe_channel,
   input  wire logic [11:0]      afe_dac_code,
   // analog level of each input, expressed as a code
   input  wire logic [7:0][11:0] level,
   // comparator result
   output logic                  afe_cmp_above
);
   // ======================================================
   // comparator: high while the selected input is at or above the dac
   assign afe_cmp_above = (level[afe_channel] >= afe_dac_code);
endmodule : adc_frontend_model

`default_nettype wire

//--- testbench/testbench.sv
// self-checking bench for the converter host port
`timescale 1ns/1ps
`default_nettype none

module testbench;
   // ======================================================
   // signals
   logic                   clk_sys         = 1'b0;
   logic                   sys_rst         = 1'b1;
   logic [31:0]            avs_address     = 32'h0;
   logic                   avs_read        = 1'b0;
   logic                   avs_write       = 1'b0;
   logic [31:0]            avs_writedata   = 32'h0;
   logic [3:0]             avs_byteenable  = 4'h0;
   logic [31:0]            avs_readdata;
   logic                   avs_waitrequest;
   logic [2:0]             afe_channel;
   logic                   afe_bipolar;
   logic                   afe_span_10v;
   logic [11:0]            afe_dac_code;
   logic                   afe_cmp_above;
   logic                   option_fitted   = 1'b0;
   logic [7:0][11:0]       level = {12'hffe, 12'h001, 12'ha5c, 12'h123,
                                    12'h7ff, 12'h800, 12'hfff, 12'h000};
   logic [31:0]            rd;
   logic [15:0]            last_res = 16'h0;
   int                     fails = 0;
   int                     n_tests = 0;
   int                     cyc = 0;
   int                     t_ack = 0;
   int                     t_start = 0;

   // ======================================================
   // clock and cycle count
   always #10 clk_sys = ~clk_sys;
   always @(posedge clk_sys) cyc <= cyc + 1;

   // ======================================================
   // design and front end
   octal_adc_host_port octal_adc_host_port_inst (
      .clk_sys(clk_sys), .sys_rst(sys_rst),
      .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .afe_channel(afe_channel),
      .afe_bipolar(afe_bipolar), .afe_span_10v(afe_span_10v),
      .afe_dac_code(afe_dac_code), .afe_cmp_above(afe_cmp_above),
      .option_fitted(option_fitted));
   adc_frontend_model adc_frontend_model_inst (
      .afe_channel(afe_channel), .afe_dac_code(afe_dac_code),
      .level(level), .afe_cmp_above(afe_cmp_above));

   // ======================================================
   // compare and report
   task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         fails++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask : chk

   task automatic chk_le(string what, int lim, int got);
      n_tests++;
      if (got > lim) begin
         fails++;
         $display("unexpected %s: expected at most %0d, seen %0d",
                  what, lim, got);
      end
   endtask : chk_le

   task automatic conclude();
      $display("checks %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : conclude

   // ======================================================
   // one avalon transfer, entered and left at a rising edge
   task automatic bus(logic wr, logic [29:0] idx, logic [31:0] wd,
                      logic [3:0] be);
      int n;
      n = 0;
      avs_address    <= {idx, 2'b00};
      avs_write      <= wr;
      avs_read       <= ~wr;
      avs_writedata  <= wd;
      avs_byteenable <= be;
      do begin
         @(posedge clk_sys);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      if (avs_waitrequest !== 1'b0) begin
         fails++;
         conclude();
      end
      rd = avs_readdata;
      t_ack = cyc;
      avs_write <= 1'b0;
      avs_read  <= 1'b0;
      @(posedge clk_sys);
   endtask : bus

   // ======================================================
   // conversion steps
   task automatic wait_idle();
      int k;
      k = 0;
      bus(1'b0, adc_port_pkg::IDX_STATUS, 32'h0, 4'hf);
      chk("busy after start", 32'h1, 32'(rd[7]));
      while (rd[7] !== 1'b0 && k < 400) begin
         bus(1'b0, adc_port_pkg::IDX_STATUS, 32'h0, 4'hf);
         k++;
      end
      if (rd[7] !== 1'b0) begin
         fails++;
         conclude();
      end
      chk_le("conversion cycles", adc_port_pkg::CONV_CYC + 4,
             t_ack - t_start);
   endtask : wait_idle

   task automatic convert(logic [2:0] ch, logic bip, logic span);
      adc_port_pkg::ctrl_t c;
      logic [11:0]         v;
      logic [15:0]         e;
      c = '{mode: 3'h2, span_10v: span, bipolar: bip, channel: ch};
      v = level[ch];
      e = bip ? {{5{~v[11]}}, v[10:0]} : {4'h0, v};
      bus(1'b1, adc_port_pkg::IDX_CONTROL, {24'h0, c}, 4'h1);
      t_start = t_ack;
      @(negedge clk_sys);
      chk("front end select", 32'({ch, bip, span}),
          32'({afe_channel, afe_bipolar, afe_span_10v}));
      @(posedge clk_sys);
      wait_idle();
      bus(1'b0, adc_port_pkg::IDX_RES_LOW, 32'h0, 4'h1);
      chk("low byte", 32'(e[7:0]), 32'(rd[7:0]));
      bus(1'b0, adc_port_pkg::IDX_RES_HIGH, 32'h0, 4'h1);
      chk("high byte", 32'(e[15:8]), rd);
      bus(1'b0, adc_port_pkg::IDX_RES_LOW, 32'h0, 4'hf);
      chk("word result", 32'(e), 32'(rd[15:0]));
      last_res = e;
   endtask : convert

   // ======================================================
   // scenarios
   task automatic idle_checks();
      bus(1'b0, adc_port_pkg::IDX_STATUS, 32'h0, 4'hf);
      chk("status after reset", 32'h0, 32'(rd[7]));
      bus(1'b0, adc_port_pkg::IDX_OPTION, 32'h0, 4'hf);
      chk("option absent", 32'h0, 32'(rd[0]));
      option_fitted <= 1'b1;
      repeat (2) @(posedge clk_sys);
      bus(1'b0, adc_port_pkg::IDX_OPTION, 32'h0, 4'hf);
      chk("option fitted", 32'h1, 32'(rd[0]));
      bus(1'b0, 30'h0000_0040, 32'h0, 4'hf);
      chk("unmapped read", 32'h0, rd);
   endtask : idle_checks

   task automatic sweep();
      int t_prev;
      t_prev = 0;
      for (int i = 0; i < 8; i++) begin
         convert(3'(i), i[0], i[1]);
         if (i > 0)
            chk_le("start spacing", adc_port_pkg::SAMPLE_CYC,
                   t_start - t_prev);
         t_prev = t_start;
      end
   endtask : sweep

   task automatic restart();
      bus(1'b0, adc_port_pkg::IDX_RES_LOW, 32'h0, 4'hf);
      chk("result kept", 32'(last_res), 32'(rd[15:0]));
      bus(1'b1, adc_port_pkg::IDX_CONTROL, 32'h0000_0044, 4'h1);
      t_start = t_ack;
      wait_idle();
      bus(1'b0, adc_port_pkg::IDX_RES_LOW, 32'h0, 4'hf);
      chk("result after restart", 32'({4'h0, level[4]}),
          32'(rd[15:0]));
      convert(3'h5, 1'b1, 1'b0);
   endtask : restart

   task automatic masked_write();
      bus(1'b1, adc_port_pkg::IDX_CONTROL, 32'h0000_0043, 4'h0);
      @(negedge clk_sys);
      chk("ignored write", 32'h5, 32'(afe_channel));
      @(posedge clk_sys);
      bus(1'b0, adc_port_pkg::IDX_STATUS, 32'h0, 4'hf);
      chk("no start", 32'h0, 32'(rd[7]));
   endtask : masked_write

   // ======================================================
   // main sequence
   initial begin
      repeat (20) @(posedge clk_sys);
      sys_rst <= 1'b0;
      @(posedge clk_sys);
      idle_checks();
      sweep();
      restart();
      masked_write();
      conclude();
   end
endmodule : testbench

`default_nettype wire

//--- verilog/octal_adc_host_port.sv
// host port for an eight-channel 12-bit converter, avalon slave
// Operation
// - a control write with byte lane 0 enabled starts one conversion
// - low three bits select channel 0..7
// - bit 3 chooses unipolar or bipolar
// - bit 4 chooses 5 V or 10 V span
// - conversion finishes within twelve microseconds
// - status bit 7 low when conversion done
// - byte reads give result low, high bytes
// - word read at base gives whole result
// - unipolar result straight binary, top nibble zero
// - bipolar result two's complement, sign extended
// - option bit 0 shows converter fitted
// - back-to-back conversions up to 60000 per second
`timescale 1ns/1ps
`default_nettype none

module octal_adc_host_port (
   // clock and reset
   input  wire logic        clk_sys,
   input  wire logic        sys_rst,
   // avalon-mm slave
   input  wire logic [31:0] avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest,
   // analog front end
   output logic [2:0]       afe_channel,
   output logic             afe_bipolar,
   output logic             afe_span_10v,
   output logic [11:0]      afe_dac_code,
   input  wire logic        afe_cmp_above,
   // board straps
   input  wire logic        option_fitted
);

   // ========================================================
   // declarations
   adc_port_pkg::avs_req_t req;
   adc_port_pkg::ctrl_t    cfg_ff;
   logic        wait_ff;
   logic [31:0] rdata_ff;
   logic [31:0] nxt_rdata;
   logic        busy_ff;
   logic        fitted_ff;
   logic [15:0] result_ff;
   logic        start_pulse;
   logic        seq_done;
   logic [11:0] seq_code;
   logic [11:0] dac_code;
   logic        wr_take;
   logic [9:0]  busy_cnt;

   // ========================================================
   // address decode: word aligned index match
   function automatic logic hit(input logic [31:0] addr,
                                input logic [29:0] idx);
      hit = (addr[1:0] == 2'h0) && (addr[31:2] == idx);
   endfunction : hit

   // result formatting by polarity
   function automatic logic [15:0] fmt_result(input logic [11:0] code,
                                              input logic bipolar);
      logic [11:0] tc;
      tc = {~code[11], code[10:0]};
      if (bipolar) begin
         fmt_result = {{4{tc[11]}}, tc};
      end else begin
         fmt_result = {4'h0, code};
      end
   endfunction : fmt_result

   // bundle the bus inputs
   assign req.address    = avs_address;
   assign req.read       = avs_read;
   assign req.write      = avs_write;
   assign req.writedata  = avs_writedata;
   assign req.byteenable = avs_byteenable;

   // ========================================================
   // bus handshake
   // waitrequest is high idle and drops for one cycle per request
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         wait_ff <= 1'b1;
      end else if (!wait_ff) begin
         wait_ff <= 1'b1;
      end else if (req.read || req.write) begin
         wait_ff <= 1'b0;
      end
   end

   // write takes effect at the edge where waitrequest is seen low
   assign wr_take = req.write && !wait_ff;
   assign start_pulse = wr_take && req.byteenable[0] &&
                        hit(req.address, adc_port_pkg::IDX_CONTROL);

   // ========================================================
   // read data mux, unmapped locations read zero
   always_comb begin
      nxt_rdata = 32'h0000_0000;
      if (hit(req.address, adc_port_pkg::IDX_RES_LOW)) begin
         nxt_rdata = {16'h0000, result_ff};
      end else if (hit(req.address, adc_port_pkg::IDX_RES_HIGH)) begin
         nxt_rdata = {24'h00_0000, result_ff[15:8]};
      end else if (hit(req.address, adc_port_pkg::IDX_STATUS)) begin
         nxt_rdata[adc_port_pkg::STATUS_BUSY_BIT] = busy_ff;
      end else if (hit(req.address, adc_port_pkg::IDX_OPTION)) begin
         nxt_rdata[adc_port_pkg::OPTION_FIT_BIT]  = fitted_ff;
         nxt_rdata[adc_port_pkg::STATUS_BUSY_BIT] = busy_ff;
      end
   end

   // read data is captured as waitrequest drops
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         rdata_ff <= 32'h0000_0000;
      end else if (wait_ff && req.read) begin
         rdata_ff <= nxt_rdata;
      end
   end

   // ========================================================
   // control byte, taken on every accepted control write with byte lane 0 enabled
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         cfg_ff.mode     <= adc_port_pkg::MODE_RESET;
         cfg_ff.span_10v <= 1'b0;
         cfg_ff.bipolar  <= 1'b0;
         cfg_ff.channel  <= 3'h0;
      end else if (start_pulse) begin
         cfg_ff.channel  <= req.writedata[2:0];
         cfg_ff.bipolar  <= req.writedata[3];
         cfg_ff.span_10v <= req.writedata[4];
         cfg_ff.mode     <= req.writedata[7:5];
      end
   end

   // ========================================================
   // busy flag: start wins over completion in the same cycle
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         busy_ff <= 1'b0;
      end else if (start_pulse) begin
         busy_ff <= 1'b1;
      end else if (seq_done) begin
         busy_ff <= 1'b0;
      end
   end

   // result store, old value stands until the new one is done
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         result_ff <= adc_port_pkg::RESULT_RESET;
      end else if (seq_done && !start_pulse) begin
         result_ff <= fmt_result(seq_code, cfg_ff.bipolar);
      end
   end

   // option strap sampled each cycle after reset release
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         fitted_ff <= 1'b0;
      end else begin
         fitted_ff <= option_fitted;
      end
   end

   // ========================================================
   // conversion sequencer
   sar_sequencer u_seq (
      .clk_sys   (clk_sys),
      .sys_rst   (sys_rst),
      .start     (start_pulse),
      .cmp_above (afe_cmp_above),
      .dac_code  (dac_code),
      .code_out  (seq_code),
      .done      (seq_done)
   );

   // ========================================================
   // outputs, all from flops
   assign avs_readdata    = rdata_ff;
   assign avs_waitrequest = wait_ff;
   assign afe_channel     = cfg_ff.channel;
   assign afe_bipolar     = cfg_ff.bipolar;
   assign afe_span_10v    = cfg_ff.span_10v;
   assign afe_dac_code    = dac_code;

   // ========================================================
   // checking helpers: cycles spent busy, cleared as the result lands
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         busy_cnt <= 10'h000;
      end else if (start_pulse) begin
         busy_cnt <= 10'h001;
      end else if (busy_ff && !seq_done) begin
         busy_cnt <= busy_cnt + 10'h001;
      end else begin
         busy_cnt <= 10'h000;
      end
   end

   localparam int CONV_MAX   = adc_port_pkg::CONV_CYC + 1;
   localparam int SAMPLE_MAX = adc_port_pkg::SAMPLE_CYC;

   sequence s_start_taken;
      start_pulse;
   endsequence

   sequence s_busy_hold;
      busy_ff [*8];
   endsequence

   // ========================================================
   // assertions
   chk_start_sets_busy: assert property (
      @(posedge clk_sys) disable iff (sys_rst)
      s_start_taken |=> s_busy_hold)
      else $error("busy not held after start");

   chk_channel_taken: assert property (
      @(posedge clk_sys) disable iff (sys_rst)
      start_pulse |=> afe_channel == $past(req.writedata[2:0]))
      else $error("channel not taken from control byte");

   chk_polarity_taken: assert property (
      @(posedge clk_sys) disable iff (sys_rst)
      start_pulse |=> afe_bipolar == $past(req.writedata[3]))
      else $error("polarity not taken from control byte");

   chk_span_taken: assert property (
      @(posedge clk_sys) disable iff (sys_rst)
      start_pulse |=> afe_span_10v == $past(req.writedata[4]))
      else $error("span not taken from control byte");

   chk_conv_bound: assert property (
      @(posedge clk_sys) disable iff (sys_rst)
      busy_cnt <= 10'(CONV_MAX))
      else $error("conversion longer than allowed");

   chk_status_read: assert property (
      @(posedge clk_sys) disable iff (sys_rst)
      wait_ff && req.read && hit(req.address, adc_port_pkg::IDX_STATUS)
      |=> avs_readdata[adc_port_pkg::STATUS_BUSY_BIT] == $past(busy_ff))
      else $error("status bit does not show busy");

   chk_high_byte: assert property (
      @(posedge clk_sys) disable iff (sys_rst)
      wait_ff && req.read && hit(req.address, adc_port_pkg::IDX_RES_HIGH)
      |=> avs_readdata == {24'h00_0000, $past(result_ff[15:8])})
      else $error("high byte read wrong");

   chk_word_read: assert property (
      @(posedge clk_sys) disable iff (sys_rst)
      wait_ff && req.read && hit(req.address, adc_port_pkg::IDX_RES_LOW)
      |=> avs_readdata == {16'h0000, $past(result_ff)})
      else $error("word read wrong");

   chk_unipolar_top: assert property (
      @(posedge clk_sys) disable iff (sys_rst)
      $changed(result_ff) && !cfg_ff.bipolar |-> result_ff[15:12] == 4'h0)
      else $error("unipolar top nibble not zero");

   chk_bipolar_sext: assert property (
      @(posedge clk_sys) disable iff (sys_rst)
      $changed(result_ff) && cfg_ff.bipolar
      |-> result_ff[15:12] == {4{result_ff[11]}})
      else $error("bipolar result not sign extended");

   chk_option_bit: assert property (
      @(posedge clk_sys) disable iff (sys_rst)
      wait_ff && req.read && hit(req.address, adc_port_pkg::IDX_OPTION)
      |=> avs_readdata[adc_port_pkg::OPTION_FIT_BIT] == $past(fitted_ff))
      else $error("option bit wrong");

   chk_sample_rate: assert property (
      @(posedge clk_sys) disable iff (sys_rst)
      busy_cnt < 10'(SAMPLE_MAX))
      else $error("conversion too slow for sample rate");

   chk_busy_until_store: assert property (
      @(posedge clk_sys) disable iff (sys_rst)
      $fell(busy_ff) |-> $past(seq_done) && busy_cnt == 10'h000)
      else $error("busy dropped before result stored");

   chk_wait_pulse: assert property (
      @(posedge clk_sys) disable iff (sys_rst)
      !wait_ff |=> wait_ff)
      else $error("waitrequest low for more than one cycle");

endmodule : octal_adc_host_port

`default_nettype wire

//--- verilog/sar_sequencer.sv
// successive approximation sequencer for one 12-bit conversion
`timescale 1ns/1ps
`default_nettype none

module sar_sequencer (
   // clock and reset
   input  wire logic        clk_sys,
   input  wire logic        sys_rst,
   // control
   input  wire logic        start,
   input  wire logic        cmp_above,
   // results
   output logic [11:0]      dac_code,
   output logic [11:0]      code_out,
   output logic             done
);

   typedef enum logic [0:0] {SEQ_IDLE, SEQ_CONVERT} seq_state_t;

   seq_state_t  state_ff;
   logic [5:0]  tick_ff;
   logic [3:0]  bit_idx_ff;
   logic [11:0] trial_ff;
   logic [11:0] nxt_trial;

   // ========================================================
   // keep the trial bit when the input sits above the dac level
   always_comb begin
      nxt_trial = trial_ff;
      if (!cmp_above) begin
         nxt_trial = trial_ff & ~(12'h001 << bit_idx_ff);
      end
   end

   // one bit decided every bit period, twelve periods in all
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         state_ff   <= SEQ_IDLE;
         tick_ff    <= 6'h00;
         bit_idx_ff <= 4'h0;
         trial_ff   <= adc_port_pkg::CODE_RESET;
         code_out   <= adc_port_pkg::CODE_RESET;
         done       <= 1'b0;
      end else begin
         done <= 1'b0;
         if (start) begin // a new start aborts any conversion
            state_ff   <= SEQ_CONVERT;
            tick_ff    <= 6'h00;
            bit_idx_ff <= 4'hb;
            trial_ff   <= 12'h800;
         end else begin
            unique case (state_ff)
               SEQ_IDLE: begin
                  tick_ff <= 6'h00;
               end
               SEQ_CONVERT: begin
                  if (tick_ff == adc_port_pkg::BIT_LAST) begin
                     tick_ff <= 6'h00;
                     if (bit_idx_ff == 4'h0) begin
                        code_out <= nxt_trial;
                        trial_ff <= nxt_trial;
                        done     <= 1'b1;
                        state_ff <= SEQ_IDLE;
                     end else begin
                        trial_ff   <= nxt_trial |
                                      (12'h001 << (bit_idx_ff - 4'h1));
                        bit_idx_ff <= bit_idx_ff - 4'h1;
                     end
                  end else begin
                     tick_ff <= tick_ff + 6'h01;
                  end
               end
            endcase
         end
      end
   end

   assign dac_code = trial_ff;

   // done is still low eight cycles after a start with no new start
   chk_done_timing: assert property (@(posedge clk_sys) disable iff (sys_rst)
      start ##1 (!start) [*8] |-> !done)
      else $error("done too early after start");

endmodule : sar_sequencer

`default_nettype wire
